// >>> core/pfac_pkg.sv
/*
 Package for the program flash access controller: APB register offsets,
 field positions, reset values, array geometry and timing counts.
 Assumes a 32-bit APB master on a 100 MHz pclk.
*/
package pfac_pkg;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [11:0] OFF_CONTROL   = 12'h000;
	localparam logic [11:0] OFF_KEY       = 12'h004;
	localparam logic [11:0] OFF_ADDR      = 12'h008;
	localparam logic [11:0] OFF_DATA      = 12'h00c;
	localparam logic [11:0] OFF_INDIRECT  = 12'h010;
	localparam logic [11:0] OFF_PROTECT   = 12'h014;

	// ==========================================================
	// Control register fields
	localparam int BIT_READ      = 0;
	localparam int BIT_WRITE     = 1;
	localparam int BIT_WRITE_ENABLE      = 2;
	localparam int BIT_ERASE     = 3;
	localparam int BIT_LATCH     = 4;
	localparam int BIT_REGION    = 5;
	localparam int BIT_DONE      = 6;
	localparam int BIT_IRQ_EN    = 7;

	// ==========================================================
	// Geometry
	localparam int WORD_W        = 14;
	localparam int ROW_WORDS     = 32;
	localparam int ADDR_W        = 15;
	localparam int FLASH_WORDS   = 8192;
	localparam int CFG_WORDS     = 16;
	localparam logic [13:0] ERASED = 14'h3fff;
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	// Region-1 words 0..3 are user identification, the rest read-only
	localparam logic [14:0] UID_LAST   = 15'h0003;

	// ==========================================================
	// Timing
	localparam int CLK_NS        = 10;
	localparam int ERASE_NS      = 2000;
	localparam int PROG_NS       = 2000;
	localparam int ERASE_CYC     = ERASE_NS / CLK_NS;
	localparam int PROG_CYC      = PROG_NS / CLK_NS;
endpackage

// >>> core/pfac_ctrl.sv
/*
 Program flash access controller: flash array, row latches, unlock
 sequencer and APB slave. Assumes a single pclk domain; each APB access
 stands for one instruction cycle of the CPU.
*/
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// Function
// - Erase sets cells one, program clears only
// - Rows of 32 fourteen-bit words, row erase
// - Latches loaded only through data register
// - Erased words programmable without row erase
// - Only word writes and row erase allowed
// - Indirect read one cycle, returns one byte
// - Indirect path writes have no effect
// - User ID writable, identity words read-only
// - Protected erase clears trigger, no action
// - Read trigger stalls, data next cycle
// - Data register holds word until replaced
// - Hardware clears read trigger on completion
// - Erase, latch load, commit need unlock
// - Keys 55h then AAh then trigger
// - Unlock steps on consecutive cycles exactly; here reads and idle cycles between steps do not break the sequence
// - Stall until operation ends, then continue
// - Writes never erase automatically
// - Completion flag set; interrupt when enabled
// - Erase keeps latches and write enable
// - Upper ten bits row, low five latch
// - Latches reset to 3FFFh after programming
// - Latch-only select loads one latch
module pfac_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	input  wire logic        write_protect,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             cpu_stall,
	output logic             completion_irq
);
	// ==========================================================
	// State
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_BUSY  = 2'b10
	} pfac_state_e;

	typedef enum logic [1:0] {
		UK_NONE  = 2'b00,
		UK_ONE   = 2'b01,
		UK_TWO   = 2'b10
	} pfac_key_e;

	// Bus answer and status live beside the sequencer state
	typedef struct packed {
		pfac_state_e state;
		pfac_key_e   key;
		logic [7:0]  ctrl;
		logic [14:0] addr;
		logic [13:0] data;
		logic [15:0] indirect;
		logic [7:0]  cnt;
		logic        erase_op;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        stall;
		logic        irq;
	} pfac_regs_s;

	pfac_regs_s r;
	pfac_regs_s next_r;

	// Array contents are not reset; software erases before use
	logic [13:0] flash [pfac_pkg::FLASH_WORDS];
	logic [13:0] cfg   [pfac_pkg::CFG_WORDS];
	logic [13:0] latch [pfac_pkg::ROW_WORDS];

	// ==========================================================
	// Decode
	logic        setup;
	logic        wr_acc;
	logic [13:0] rd_word;
	logic [13:0] ind_word;
	logic        target_prot;
	logic [4:0]  lat_idx;
	logic [9:0]  row_idx;
	logic        do_erase;
	logic        do_prog;
	logic        do_latch;
	logic        trig_read;
	logic        trig_store;
	logic [7:0]  ind_byte;

	// A request is answered once; one seen while stalled waits for idle
	assign setup   = psel && !r.pready;
	// Read wins over a store written in the same word
	assign trig_read  = pstrb[0] && pwdata[pfac_pkg::BIT_READ];
	assign trig_store = pstrb[0] && pwdata[pfac_pkg::BIT_WRITE] &&
		pwdata[pfac_pkg::BIT_WRITE_ENABLE] && r.key == UK_TWO;
	assign wr_acc  = psel && penable && pwrite && r.pready;
	assign lat_idx = r.addr[4:0];
	assign row_idx = r.addr[14:5];

	// ==========================================================
	// Read mux
	always_comb begin
		if (r.ctrl[pfac_pkg::BIT_REGION])
			rd_word = cfg[r.addr[3:0]];
		else
			rd_word = flash[r.addr[12:0]];
	end

	// ==========================================================
	// Indirect path
	// Indirect pointer bits 12:0 pick the flash word; bit 15 is not decoded, data memory lives elsewhere
	assign ind_word = flash[r.indirect[12:0]];

	// Indirect read yields one byte: pointer bit 0 picks the high half
	always_comb begin
		if (r.indirect[0])
			ind_byte = {2'b00, ind_word[13:8]};
		else
			ind_byte = ind_word[7:0];
	end

	// ==========================================================
	// Store guard
	// Identity and configuration words never accept a store
	assign target_prot = write_protect ||
		(r.ctrl[pfac_pkg::BIT_REGION] && (r.addr > pfac_pkg::UID_LAST));

	// ==========================================================
	// Next state
	always_comb begin
		next_r         = r;
		next_r.pready  = 1'b0;
		next_r.pslverr = 1'b0;
		do_erase       = 1'b0;
		do_prog        = 1'b0;
		do_latch       = 1'b0;
		// Key window survives reads; any write to a register other than key or control breaks it
		if (wr_acc && paddr != pfac_pkg::OFF_KEY &&
			paddr != pfac_pkg::OFF_CONTROL)
			next_r.key = UK_NONE;
		unique case (r.state)
		ST_IDLE: begin
			// Answer comes one cycle after the request is seen
			if (setup) begin
				next_r.pready = 1'b1;
			end
			if (wr_acc) begin
				unique case (paddr)
				pfac_pkg::OFF_KEY: begin
					// A fresh 55h restarts the sequence from its first step
					if (pstrb[0] && pwdata[7:0] == pfac_pkg::KEY_FIRST)
						next_r.key = UK_ONE;
					else if (pstrb[0] && r.key == UK_ONE &&
						pwdata[7:0] == pfac_pkg::KEY_SECOND)
						next_r.key = UK_TWO;
					else
						next_r.key = UK_NONE;
				end

				pfac_pkg::OFF_CONTROL: begin
					next_r.key = UK_NONE;
					if (pstrb[0]) begin
						next_r.ctrl[5:2] = pwdata[5:2];
						next_r.ctrl[pfac_pkg::BIT_IRQ_EN] = pwdata[7];
						// Flag clears by writing zero, but a new completion wins
						if (!pwdata[pfac_pkg::BIT_DONE])
							next_r.ctrl[pfac_pkg::BIT_DONE] = 1'b0;
						if (trig_read) begin
							next_r.ctrl[pfac_pkg::BIT_READ] = 1'b1;
							next_r.state = ST_READ;
							next_r.stall = 1'b1;
						end else if (trig_store) begin
							// Refused stores leave the trigger clear for software
							if (target_prot) begin
								next_r.ctrl[pfac_pkg::BIT_WRITE] = 1'b0;
							end else if (pwdata[pfac_pkg::BIT_ERASE]) begin
								next_r.ctrl[pfac_pkg::BIT_WRITE] = 1'b1;
								next_r.erase_op = 1'b1;
								next_r.cnt   = 8'(pfac_pkg::ERASE_CYC);
								next_r.state = ST_BUSY;
								next_r.stall = 1'b1;
							end else if (pwdata[pfac_pkg::BIT_LATCH]) begin
								do_latch = 1'b1;
							end else begin
								next_r.ctrl[pfac_pkg::BIT_WRITE] = 1'b1;
								next_r.erase_op = 1'b0;
								next_r.cnt   = 8'(pfac_pkg::PROG_CYC);
								next_r.state = ST_BUSY;
								next_r.stall = 1'b1;
							end
						end
					end
				end

				pfac_pkg::OFF_ADDR: begin
					// The top bit of the high byte has no address line
					if (pstrb[0])
						next_r.addr[7:0] = pwdata[7:0];
					if (pstrb[1])
						next_r.addr[14:8] = pwdata[14:8];
				end

				pfac_pkg::OFF_DATA: begin
					// A software store replaces the last read word
					if (pstrb[0])
						next_r.data[7:0] = pwdata[7:0];
					if (pstrb[1])
						next_r.data[13:8] = pwdata[13:8];
				end

				pfac_pkg::OFF_INDIRECT: begin
					// Pointer only; stores through it never reach flash
					if (pstrb[0])
						next_r.indirect[7:0] = pwdata[7:0];
					if (pstrb[1])
						next_r.indirect[15:8] = pwdata[15:8];
				end
				// Unmapped stores are dropped without an error
				default: next_r.pslverr = 1'b0;
				endcase
			end
			// Read data is registered together with the answer
			if (setup && !pwrite) begin
				unique case (paddr)
				pfac_pkg::OFF_CONTROL:  next_r.prdata = {24'h0, r.ctrl};
				pfac_pkg::OFF_ADDR:     next_r.prdata = {17'h0, r.addr};
				pfac_pkg::OFF_DATA:     next_r.prdata = {18'h0, r.data};
				pfac_pkg::OFF_INDIRECT: next_r.prdata = {24'h0, ind_byte};
				pfac_pkg::OFF_PROTECT:  next_r.prdata = {31'h0, write_protect};
				default: begin
					next_r.prdata  = 32'h0;
					next_r.pslverr = 1'b1;
				end
				endcase
			end
		end

		ST_READ: begin
			// One stall cycle stands for the suspended instruction
			next_r.data = rd_word;
			next_r.ctrl[pfac_pkg::BIT_READ] = 1'b0;
			next_r.stall = 1'b0;
			next_r.state = ST_IDLE;
		end

		ST_BUSY: begin
			// Array changes on the last busy cycle, so a read that was
			// held off by the stall sees the new contents
			if (r.cnt == 8'h01) begin
				if (r.erase_op)
					do_erase = 1'b1;
				else
					do_prog = 1'b1;
				next_r.ctrl[pfac_pkg::BIT_WRITE] = 1'b0;
				next_r.ctrl[pfac_pkg::BIT_DONE]  = 1'b1;
				next_r.stall = 1'b0;
				next_r.state = ST_IDLE;
			end else begin
				next_r.cnt = r.cnt - 8'h01;
			end
		end
		// Unused code returns to idle
		default: next_r.state = ST_IDLE;
		endcase
		// Level follows the flag, so clearing the flag drops it
		next_r.irq = next_r.ctrl[pfac_pkg::BIT_DONE] &&
			next_r.ctrl[pfac_pkg::BIT_IRQ_EN];
	end

	// ==========================================================
	// Registers
	// Whole state in one register; the arrays below are kept apart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Latches and user IDs
	// Array storage has no reset; erased state is written by operations
	generate
		// Latches reset only after a commit, never on an erase
		for (genvar i = 0; i < pfac_pkg::ROW_WORDS; i++) begin : g_row
			always_ff @(posedge pclk) begin
				if (do_latch && lat_idx == 5'(i))
					latch[i] <= r.data;
				else if (do_prog)
					latch[i] <= pfac_pkg::ERASED;
			end
		end
		// Only the user ID words take stores; the rest stay as built
		for (genvar j = 0; j < pfac_pkg::CFG_WORDS; j++) begin : g_cfg
			always_ff @(posedge pclk) begin
				if (j <= 3 && do_erase && r.ctrl[pfac_pkg::BIT_REGION])
					cfg[j] <= pfac_pkg::ERASED;
				else if (j <= 3 && do_prog && r.ctrl[pfac_pkg::BIT_REGION])
					cfg[j] <= cfg[j] & latch[j];
			end
		end
	endgenerate

	// ==========================================================
	// Flash array
	// One process owns the whole array: a row index that moves at
	// run time would otherwise let every loop copy claim all of it
	always_ff @(posedge pclk) begin
		for (int w = 0; w < pfac_pkg::ROW_WORDS; w++) begin
			if (do_erase && !r.ctrl[pfac_pkg::BIT_REGION])
				flash[{row_idx[7:0], 5'(w)}] <= pfac_pkg::ERASED;
			else if (do_prog && !r.ctrl[pfac_pkg::BIT_REGION])
				flash[{row_idx[7:0], 5'(w)}] <=
					flash[{row_idx[7:0], 5'(w)}] & latch[w];
		end
	end

	// ==========================================================
	// Outputs
	assign prdata         = r.prdata;
	assign pready         = r.pready;
	assign pslverr        = r.pslverr;
	assign cpu_stall      = r.stall;
	assign completion_irq = r.irq;
endmodule // pfac_ctrl

// >>> sim/pfac_ctrl_sva.sv
/* Port assertions for the flash access controller.
 Assumes one pclk domain; bound to pfac_ctrl at the foot of this file. */
`timescale 1ns/1ps
module pfac_ctrl_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        write_protect,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cpu_stall,
	input wire logic        completion_irq
);
	// ====
	// Helpers: taken transfer, control writes, last key seen
	wire  tk = psel && penable && pready;
	wire  cw = tk && pwrite && paddr == pfac_pkg::OFF_CONTROL;
	wire  go = cw && pwdata[1] && !pwdata[0];
	logic key_ok;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			key_ok <= 1'b0;
		else if (tk)
			key_ok <= pwrite && paddr == pfac_pkg::OFF_KEY && pwdata[7:0] == pfac_pkg::KEY_SECOND;
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ====
	// Properties
	chk_read_stall: assert property (cw && pwdata[0] && !pwdata[1] |=> cpu_stall ##1 !cpu_stall)
		else $error("read stall not one cycle");
	chk_stall_quiet: assert property (cpu_stall |-> !pready)
		else $error("answer during stall");
	chk_stall_bound: assert property ($rose(cpu_stall) |-> ##[1:300] !cpu_stall)
		else $error("stall too long");
	chk_no_key: assert property (go && !key_ok |=> !cpu_stall)
		else $error("operation without keys");
	chk_no_write_enable: assert property (go && !pwdata[2] |=> !cpu_stall)
		else $error("operation without write enable");
	chk_protect: assert property (go && write_protect |=> !cpu_stall)
		else $error("operation while protected");
	chk_irq_cause: assert property ($rose(completion_irq) |-> $past(cpu_stall) || $past(tk))
		else $error("interrupt without completion");
	chk_byte_only: assert property (tk && !pwrite && paddr == pfac_pkg::OFF_INDIRECT |-> prdata[31:8] == 24'h0)
		else $error("indirect read wider than a byte");
endmodule // pfac_ctrl_sva

bind pfac_ctrl pfac_ctrl_sva u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .write_protect(write_protect),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall),
	.completion_irq(completion_irq)
);

// >>> sim/pfac_cpu_model.sv
/* CPU core model: APB master for register accesses and unlock.
 Assumes calls start just after a pclk edge, reset released. */
`timescale 1ns/1ps
module pfac_cpu_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	output logic             hung
);
	bit free = 1'b1;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		hung = 1'b0;
	end
	// ====
	// One transfer; k keeps psel up so the next setup follows at once
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic k, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		if (free)
			@(posedge pclk);
		free = !k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (!pready && n < 1000);
		hung <= !pready;
		r = prdata;
		e = pslverr;
		penable <= 1'b0;
		if (!k) begin
			psel <= 1'b0;
			paddr <= ~a;
			pwdata <= ~d;
		end
	endtask
	// Keys and trigger back to back, nothing may slip in between
	task automatic unlock(input logic [31:0] c);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, pfac_pkg::OFF_KEY, {24'h0, pfac_pkg::KEY_FIRST}, 1'b1, r, e);
		xfer(1'b1, pfac_pkg::OFF_KEY, {24'h0, pfac_pkg::KEY_SECOND}, 1'b1, r, e);
		xfer(1'b1, pfac_pkg::OFF_CONTROL, c, 1'b0, r, e);
	endtask
endmodule // pfac_cpu_model

// >>> sim/pfac_ctrl_tb.sv
/* Self-checking bench for pfac_ctrl: register rows, erase, program,
 indirect read, refused triggers. Assumes the CPU model as bus master. */
`timescale 1ns/1ps
module pfac_ctrl_tb;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d;} pfac_row_s;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        write_protect = 1'b0;
	logic [3:0]  pstrb = 4'hf;
	logic        psel, penable, pwrite, pready, pslverr, cpu_stall, completion_irq, hung, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int          bad_count = 0;
	int          n_tests = 0;
	pfac_row_s   rows[7] = '{'{1, pfac_pkg::OFF_ADDR, 32'h7fff}, '{0, pfac_pkg::OFF_ADDR, 32'h7fff},
		'{1, pfac_pkg::OFF_DATA, 32'h3fff}, '{0, pfac_pkg::OFF_DATA, 32'h3fff},
		'{1, pfac_pkg::OFF_CONTROL, 32'h80}, '{0, pfac_pkg::OFF_CONTROL, 32'h80}, '{0, 12'h100, 0}};
	always #5 pclk = ~pclk;
	pfac_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.write_protect(write_protect), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_stall(cpu_stall), .completion_irq(completion_irq));
	pfac_cpu_model u_cpu (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.hung(hung));
	// ====
	// Tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_cpu.xfer(1'b1, a, d, 1'b0, r, e);
	endtask
	task automatic rd(input logic [11:0] a);
		u_cpu.xfer(1'b0, a, 32'h0, 1'b0, r, e);
	endtask
	task automatic word(input logic [31:0] a, input logic [31:0] x);
		wr(pfac_pkg::OFF_ADDR, a);
		wr(pfac_pkg::OFF_CONTROL, 32'h1);
		rd(pfac_pkg::OFF_DATA);
		chk(r, x);
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge hung) begin
		bad_count++;
		end_of_test();
	end
	// ====
	// Sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			u_cpu.xfer(rows[i].w, rows[i].a, rows[i].d, 1'b0, r, e);
			if (!rows[i].w)
				chk(r, rows[i].d);
		end
		chk({31'h0, e}, 32'h1);
		pstrb <= 4'h1;
		wr(pfac_pkg::OFF_ADDR, 32'h0012);
		pstrb <= 4'hf;
		rd(pfac_pkg::OFF_ADDR);
		chk(r, 32'h7f12);
		// Empty commit first so every latch holds the erased value
		wr(pfac_pkg::OFF_ADDR, 32'h60);
		wr(pfac_pkg::OFF_CONTROL, 32'h84);
		u_cpu.unlock(32'h86);
		wr(pfac_pkg::OFF_ADDR, 32'h41);
		wr(pfac_pkg::OFF_CONTROL, 32'h8c);
		u_cpu.unlock(32'h8e);
		rd(pfac_pkg::OFF_CONTROL);
		chk(r, 32'hcc);
		chk({31'h0, completion_irq}, 32'h1);
		word(32'h5f, 32'h3fff);
		rd(pfac_pkg::OFF_CONTROL);
		chk(r, 32'h0);
		wr(pfac_pkg::OFF_ADDR, 32'h41);
		wr(pfac_pkg::OFF_DATA, 32'h1234);
		wr(pfac_pkg::OFF_CONTROL, 32'h14);
		u_cpu.unlock(32'h16);
		wr(pfac_pkg::OFF_CONTROL, 32'h04);
		u_cpu.unlock(32'h06);
		word(32'h41, 32'h1234);
		word(32'h42, 32'h3fff);
		wr(pfac_pkg::OFF_INDIRECT, 32'h41);
		rd(pfac_pkg::OFF_INDIRECT);
		chk(r, 32'h12);
		u_cpu.unlock(32'h0a);
		wr(pfac_pkg::OFF_CONTROL, 32'h0e);
		write_protect <= 1'b1;
		u_cpu.unlock(32'h0e);
		write_protect <= 1'b0;
		rd(pfac_pkg::OFF_CONTROL);
		chk(r, 32'h0c);
		word(32'h41, 32'h1234);
		end_of_test();
	end
endmodule // pfac_ctrl_tb
